/* acmp_front_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acmp_front_model (
	// Clock
	input wire logic clk_i,
	// Selections from the block, levels from the bench
	input wire acmp_pkg::acmp_ana_t [1:0] ana_i,
	input wire logic [1:0] above_i,
	// Decisions
	output logic [1:0] raw_o
);
	logic [1:0] junk_q = 2'h1;
	always @(posedge clk_i) begin
		junk_q <= ~junk_q;
	end
	// An open input gives no usable decision, so it wanders.
	for (genvar c = 0; c < 2; c++) begin : g_ch
		assign raw_o[c] = (ana_i[c].pos_connect && ana_i[c].neg_connect) ?
			above_i[c] : junk_q[c];
	end
endmodule
`default_nettype wire

/* acmp_pkg.sv */
`default_nettype none
package acmp_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int NCH = 2;
	localparam int SEL_W = 3;
	localparam int ADR_W = 8;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] OFS_CH_STRIDE = 8'h10;
	localparam logic [7:0] OFS_CTRL_FIRST = 8'h00;
	localparam logic [7:0] OFS_CTRL_SECOND = 8'h04;
	localparam logic [7:0] OFS_INV_SELECT = 8'h08;
	localparam logic [7:0] OFS_NONINV_SELECT = 8'h0c;
	localparam logic [7:0] OFS_RESULT_MIRROR = 8'h20;
	localparam logic [7:0] OFS_IRQ_FLAG = 8'h24;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int BIT_ENABLE = 7;
	localparam int BIT_RESULT = 6;
	localparam int BIT_INVERT = 4;
	localparam int BIT_HYST = 1;
	localparam int BIT_RESYNC = 0;
	localparam int BIT_RISE_EN = 1;
	localparam int BIT_FALL_EN = 0;
	localparam int SEL_LSB = 0;

	// ************************************************************
	// Channel select codes
	// ************************************************************
	localparam logic [2:0] PSEL_PIN0 = 3'h0;
	localparam logic [2:0] PSEL_PIN1 = 3'h1;
	localparam logic [2:0] PSEL_DAC = 3'h5;
	localparam logic [2:0] PSEL_FVR = 3'h6;
	localparam logic [2:0] PSEL_GND = 3'h7;
	localparam logic [2:0] NSEL_PIN_MAX = 3'h3;
	localparam logic [2:0] NSEL_FVR = 3'h6;
	localparam logic [2:0] NSEL_GND = 3'h7;

	// ************************************************************
	// Types and reset values
	// ************************************************************
	typedef struct packed {
		logic enable;
		logic invert;
		logic hyst;
		logic resync;
		logic rise_en;
		logic fall_en;
		logic [2:0] neg_sel;
		logic [2:0] pos_sel;
	} acmp_ctrl_t;

	typedef struct packed {
		logic enable;
		logic hyst;
		logic pos_connect;
		logic [2:0] pos_sel;
		logic neg_connect;
		logic [2:0] neg_sel;
	} acmp_ana_t;

	localparam acmp_ctrl_t CTRL_RESET = '0;
	localparam acmp_ana_t ANA_RESET = '0;

endpackage
`default_nettype wire

/* acmp_top.sv */
// Overview of operation
// [R1] Enable bit powers comparator, clear powers down
// [R2] Result readable in control and mirror registers
// [R3] Result goes to pin; software sets direction
// [R4] Result latched every instruction cycle
// [R5] Without resync, external output follows latch directly
// [R6] Invert bit flips the comparison result
// [R7] Hysteresis only while its bit is set
// [R8] Result offered as Timer1 gate source
// [R9] Resync latches on Timer1 clock falling edge
// [R10] Timer1 counts rising, latch updates falling
// [R11] Software should resync when gating Timer1
// [R12] Rise and fall detectors set flag
// [R13] Software enables all levels for interrupts
// [R14] Software clears flag; new edge wins
// [R15] Invert or enable toggle can cause edge
// [R16] Three-bit positive select picks input source
// [R17] Disabled comparator disconnects all inputs
// [R18] Three-bit negative select picks input source
// [R19] Result indeterminate after selection change
// [R20] Input pins need analog select, direction set
// [R21] Positive select code map
// [R22] Negative select code map
// [R23] Edge enables at bits one and zero
// [R24] Mirror holds channel outputs bits one, zero
// [R25] Two identical comparator channels
// [R26] Edges seen on latched adjusted output
`timescale 1ns/1ps
`default_nettype none
module acmp_top #(
	parameter int NCH = acmp_pkg::NCH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [acmp_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Analog front end
	input wire logic [NCH-1:0] cmp_raw_i,
	output var acmp_pkg::acmp_ana_t [NCH-1:0] ana_o,
	// Timer1 source clock after prescaler
	input wire logic tmr1_clk_i,
	// Result outputs
	output logic [NCH-1:0] tmr1_gate_o,
	output logic [NCH-1:0] pin_out_o,
	output logic [NCH-1:0] result_o,
	output logic [NCH-1:0] irq_flag_o
);

	// ************************************************************
	// Helper functions
	// ************************************************************

	// Positive select codes that actually connect a source.
	function automatic logic pos_valid(input logic [2:0] code);
		pos_valid = (code == acmp_pkg::PSEL_PIN0) ||
			(code == acmp_pkg::PSEL_PIN1) ||
			(code == acmp_pkg::PSEL_DAC) ||
			(code == acmp_pkg::PSEL_FVR) ||
			(code == acmp_pkg::PSEL_GND);
	endfunction

	// Negative select codes that actually connect a source.
	function automatic logic neg_valid(input logic [2:0] code);
		neg_valid = (code <= acmp_pkg::NSEL_PIN_MAX) ||
			(code == acmp_pkg::NSEL_FVR) ||
			(code == acmp_pkg::NSEL_GND);
	endfunction

	// Byte offset of a channel register.
	function automatic logic [7:0] ch_ofs(input int ch,
			input logic [7:0] ofs);
		ch_ofs = 8'(ch) * acmp_pkg::OFS_CH_STRIDE + ofs;
	endfunction

	// ************************************************************
	// Registers
	// ************************************************************
	acmp_pkg::acmp_ctrl_t ctrl_q [NCH];
	acmp_pkg::acmp_ana_t [NCH-1:0] ana_q;
	logic [NCH-1:0] raw_meta_q;
	logic [NCH-1:0] raw_sync_q;
	logic tclk_meta_q;
	logic tclk_sync_q;
	logic tclk_prev_q;
	logic [NCH-1:0] result_q;
	logic [NCH-1:0] result_prev_q;
	logic [NCH-1:0] resync_q;
	logic [NCH-1:0] ext_q;
	logic [NCH-1:0] flag_q;
	logic [NCH-1:0] flag_d;
	logic ack_q;
	logic [31:0] dat_q;

	// ************************************************************
	// Bus decode
	// ************************************************************
	// A strobe held while ack stands is not taken a second time.
	wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
	wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
	wire [7:0] wdat = wb_dat_i[7:0];
	wire [7:0] adr = {wb_adr_i[7:2], 2'b00};
	wire hit_mirror = (adr == acmp_pkg::OFS_RESULT_MIRROR);
	wire hit_flag = (adr == acmp_pkg::OFS_IRQ_FLAG);
	wire tclk_fall = tclk_prev_q && !tclk_sync_q;

	logic [NCH-1:0] hit_first;
	logic [NCH-1:0] hit_second;
	logic [NCH-1:0] hit_inv;
	logic [NCH-1:0] hit_noninv;
	logic [NCH-1:0] wr_first;
	logic [NCH-1:0] wr_second;
	logic [NCH-1:0] wr_inv;
	logic [NCH-1:0] wr_noninv;
	logic [NCH-1:0] eff;
	logic [NCH-1:0] res_d;
	logic [NCH-1:0] rise;
	logic [NCH-1:0] fall;
	logic [NCH-1:0] set_evt;
	logic [NCH-1:0] clr_evt;
	logic [7:0] rd_first [NCH];
	logic [7:0] rd_second [NCH];
	logic [7:0] rd_inv [NCH];
	logic [7:0] rd_noninv [NCH];

	// ************************************************************
	// Per-channel datapath
	// ************************************************************
	for (genvar c = 0; c < NCH; c++) begin : g_ch // [R25]
		// Each channel owns a block of four registers at its own stride.
		assign hit_first[c] = (adr == ch_ofs(c,
			acmp_pkg::OFS_CTRL_FIRST));
		assign hit_second[c] = (adr == ch_ofs(c,
			acmp_pkg::OFS_CTRL_SECOND));
		assign hit_inv[c] = (adr == ch_ofs(c,
			acmp_pkg::OFS_INV_SELECT));
		assign hit_noninv[c] = (adr == ch_ofs(c,
			acmp_pkg::OFS_NONINV_SELECT));

		// Write strobes, one for each register of the channel.
		assign wr_first[c] = bus_wr && hit_first[c];
		assign wr_second[c] = bus_wr && hit_second[c];
		assign wr_inv[c] = bus_wr && hit_inv[c];
		assign wr_noninv[c] = bus_wr && hit_noninv[c];

		// A powered-down comparator reads as a low raw result.
		assign eff[c] = ctrl_q[c].enable && raw_sync_q[c]; // [R1]
		assign res_d[c] = eff[c] ^ ctrl_q[c].invert; // [R6] [R15]

		assign rise[c] = result_q[c] && !result_prev_q[c]; // [R26]
		assign fall[c] = !result_q[c] && result_prev_q[c]; // [R26]
		assign set_evt[c] = (rise[c] && ctrl_q[c].rise_en) ||
			(fall[c] && ctrl_q[c].fall_en); // [R12] [R23]
		// Clearing a flag takes a one in its bit; zeros leave it alone.
		assign clr_evt[c] = bus_wr && hit_flag && wdat[c];
		// A new edge wins over a clear in the same cycle.
		assign flag_d[c] = (flag_q[c] && !clr_evt[c]) ||
			set_evt[c]; // [R14]

		// Unused bits of every register read as zero.
		assign rd_first[c] = {ctrl_q[c].enable, result_q[c], 1'b0,
			ctrl_q[c].invert, 2'b00, ctrl_q[c].hyst,
			ctrl_q[c].resync}; // [R2]
		assign rd_second[c] = {6'h00, ctrl_q[c].rise_en,
			ctrl_q[c].fall_en}; // [R23]
		assign rd_inv[c] = {5'h00, ctrl_q[c].neg_sel};
		assign rd_noninv[c] = {5'h00, ctrl_q[c].pos_sel};
	end

	// ************************************************************
	// Read data selection
	// ************************************************************
	// Unmapped addresses read as zero and are still acknowledged.
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (hit_mirror) begin
			rd_byte = 8'(result_q); // [R2] [R24]
		end else if (hit_flag) begin
			rd_byte = 8'(flag_q);
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (hit_first[c]) begin
					rd_byte = rd_first[c];
				end else if (hit_second[c]) begin
					rd_byte = rd_second[c];
				end else if (hit_inv[c]) begin
					rd_byte = rd_inv[c];
				end else if (hit_noninv[c]) begin
					rd_byte = rd_noninv[c];
				end
			end
		end
	end

	// ************************************************************
	// Wishbone handshake
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= bus_req;
			dat_q <= bus_req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// ************************************************************
	// Control register writes
	// ************************************************************
	// Only the low byte lane carries register bits; sel[0] gates it.
	always_ff @(posedge clk_i) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_i) begin
				ctrl_q[c] <= acmp_pkg::CTRL_RESET;
			end else if (wr_first[c]) begin
				ctrl_q[c].enable <= wdat[acmp_pkg::BIT_ENABLE];
				ctrl_q[c].invert <= wdat[acmp_pkg::BIT_INVERT];
				ctrl_q[c].hyst <= wdat[acmp_pkg::BIT_HYST];
				ctrl_q[c].resync <= wdat[acmp_pkg::BIT_RESYNC];
			end else if (wr_second[c]) begin
				ctrl_q[c].rise_en <= wdat[acmp_pkg::BIT_RISE_EN];
				ctrl_q[c].fall_en <= wdat[acmp_pkg::BIT_FALL_EN];
			end else if (wr_inv[c]) begin
				ctrl_q[c].neg_sel <= wdat[acmp_pkg::SEL_LSB +: 3];
			end else if (wr_noninv[c]) begin
				ctrl_q[c].pos_sel <= wdat[acmp_pkg::SEL_LSB +: 3];
			end
		end
	end

	// ************************************************************
	// Analog control outputs
	// ************************************************************
	// The analog side sees a setting one cycle after its write.
	always_ff @(posedge clk_i) begin
		for (int c = 0; c < NCH; c++) begin
			if (rst_i) begin
				ana_q[c] <= acmp_pkg::ANA_RESET;
			end else begin
				ana_q[c].enable <= ctrl_q[c].enable; // [R1]
				ana_q[c].hyst <= ctrl_q[c].enable &&
					ctrl_q[c].hyst; // [R7]
				// Unconnected codes and a disabled channel float.
				ana_q[c].pos_connect <= ctrl_q[c].enable &&
					pos_valid(ctrl_q[c].pos_sel); // [R16] [R17] [R21]
				ana_q[c].pos_sel <= ctrl_q[c].enable ?
					ctrl_q[c].pos_sel : 3'h0; // [R17]
				ana_q[c].neg_connect <= ctrl_q[c].enable &&
					neg_valid(ctrl_q[c].neg_sel); // [R18] [R17] [R22]
				ana_q[c].neg_sel <= ctrl_q[c].enable ?
					ctrl_q[c].neg_sel : 3'h0; // [R17]
			end
		end
	end

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	// The Timer1 clock is sampled like a pin, so each of its phases must
	// last at least one instruction cycle to be seen.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			raw_meta_q <= '0;
			raw_sync_q <= '0;
			tclk_meta_q <= 1'b0;
			tclk_sync_q <= 1'b0;
			tclk_prev_q <= 1'b0;
		end else begin
			raw_meta_q <= cmp_raw_i;
			raw_sync_q <= raw_meta_q;
			tclk_meta_q <= tmr1_clk_i;
			tclk_sync_q <= tclk_meta_q;
			tclk_prev_q <= tclk_sync_q;
		end
	end

	// ************************************************************
	// Result latch, resync latch, flags
	// ************************************************************
	// The previous copy feeds the edge detectors of both directions.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_q <= '0;
			result_prev_q <= '0;
			flag_q <= '0;
		end else begin
			result_q <= res_d; // [R4]
			result_prev_q <= result_q; // [R26]
			flag_q <= flag_d; // [R12] [R14]
		end
	end

	// The resync copy moves only when the Timer1 clock falls, so the
	// timer, which counts on the rising edge, never sees it change.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resync_q <= '0;
		end else if (tclk_fall) begin
			resync_q <= result_q; // [R9] [R10]
		end
	end

	// ************************************************************
	// External outputs
	// ************************************************************
	// Without resync the outputs take res_d one flop later, so every
	// output still leaves from a register.
	logic [NCH-1:0] ext_d;
	for (genvar c = 0; c < NCH; c++) begin : g_ext
		assign ext_d[c] = ctrl_q[c].resync ? resync_q[c] :
			res_d[c]; // [R5] [R9]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_q <= '0;
		end else begin
			ext_q <= ext_d;
		end
	end

	// ************************************************************
	// Port outputs
	// ************************************************************
	assign tmr1_gate_o = ext_q; // [R8]
	assign pin_out_o = ext_q; // [R3]
	assign result_o = result_q;
	assign irq_flag_o = flag_q;
	assign ana_o = ana_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

endmodule
`default_nettype wire

/* acmp_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module acmp_top_props #(
	parameter int NCH = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [acmp_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Comparator side
	input wire logic [NCH-1:0] cmp_raw_i,
	input wire acmp_pkg::acmp_ana_t [NCH-1:0] ana_o,
	input wire logic tmr1_clk_i,
	input wire logic [NCH-1:0] tmr1_gate_o,
	input wire logic [NCH-1:0] pin_out_o,
	input wire logic [NCH-1:0] result_o,
	input wire logic [NCH-1:0] irq_flag_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_read(logic [7:0] a);
		s_take ##0 (!wb_we_i && wb_adr_i == a);
	endsequence
	sequence s_write(logic [7:0] a);
		s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == a);
	endsequence
	chk_ack_once: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack is not one pulse after a request");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	chk_mirror_read: assert property (s_read(8'h20) |=>
		wb_dat_o == 32'($past(result_o)))
		else $error("mirror read differs from result");
	chk_result_bit: assert property (s_read(8'h00) |=>
		wb_dat_o[6] == $past(result_o[0]))
		else $error("control result bit differs from result");
	chk_enable_ana: assert property (s_write(8'h00) ##0 wb_dat_i[7] |=>
		##1 ana_o[0].enable)
		else $error("enable did not reach analog side");
	chk_gate_pin: assert property (tmr1_gate_o == pin_out_o)
		else $error("gate and pin outputs differ");
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		chk_off_isolated: assert property (!ana_o[c].enable |->
			ana_o[c] == '0)
			else $error("disabled channel still connected");
		chk_flag_cause: assert property ($rose(irq_flag_o[c]) |->
			$past(result_o[c]) != $past(result_o[c], 2) ||
			$past(result_o[c], 2) != $past(result_o[c], 3))
			else $error("flag rose without an output edge");
		chk_flag_clear: assert property ($fell(irq_flag_o[c]) |->
			$past(wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
			wb_sel_i[0] && wb_adr_i == 8'h24 && wb_dat_i[c]))
			else $error("flag fell without a clearing write");
	end
endmodule
bind acmp_top acmp_top_props #(.NCH(NCH)) u_props (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.cmp_raw_i(cmp_raw_i), .ana_o(ana_o), .tmr1_clk_i(tmr1_clk_i),
	.tmr1_gate_o(tmr1_gate_o), .pin_out_o(pin_out_o),
	.result_o(result_o), .irq_flag_o(irq_flag_o));
`default_nettype wire

/* analog_comparator_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_control_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tclk = 1'b0, ack;
	logic [7:0] adr = 8'h0, seed = 8'h42;
	logic [3:0] sel = 4'hf;
	logic [31:0] wdat = 32'h0, dat;
	logic [1:0] above = 2'h0, raw, gate, pin, res, flag, r, f, prev;
	acmp_pkg::acmp_ana_t [1:0] ana;
	logic [7:0] q[$];
	int err_total = 0, num_checks = 0;
	always #5 clk_i = ~clk_i;
	acmp_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .cmp_raw_i(raw),
		.ana_o(ana), .tmr1_clk_i(tclk), .tmr1_gate_o(gate),
		.pin_out_o(pin), .result_o(res), .irq_flag_o(flag));
	acmp_front_model u_front (.clk_i(clk_i), .ana_i(ana), .above_i(above),
		.raw_o(raw));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic [7:0] e);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		if (!w) q.push_back(e);
		// The wait for ack has no limit of its own; only the watchdog ends a hung one.
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0) begin
			check(dat, {24'h0, q.pop_front()}, "read data");
		end
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int c = 0; c < 16; c++) begin
			bus(1'b0, 8'(c * 4), 8'h0, 8'h0);
		end
		bus(1'b1, 8'h34, 8'hff, 8'h0);
		bus(1'b0, 8'h34, 8'h0, 8'h0);
		sel <= 4'h0;
		bus(1'b1, 8'h14, 8'h03, 8'h0);
		sel <= 4'hf;
		bus(1'b0, 8'h14, 8'h0, 8'h0);
		bus(1'b1, 8'h00, 8'h82, 8'h0);
		settle(0);
		check(32'(ana[0].hyst), 32'h1, "hysteresis");
		for (int p = 0; p < 8; p++) begin
			bus(1'b1, 8'h0c, 8'(p), 8'h0);
			bus(1'b1, 8'h08, 8'(p), 8'h0);
			settle(0);
			r = {p < 2 || p > 4, p < 4 || p > 5};
			f = {ana[0].pos_connect, ana[0].neg_connect};
			check(32'(f), 32'(r), "connect");
			check(32'(ana[0].pos_sel), 32'(p), "pos select");
			check(32'(ana[0].neg_sel), 32'(p), "neg select");
		end
		bus(1'b1, 8'h00, 8'h00, 8'h0);
		settle(0);
		check(32'(ana[0]), 32'(acmp_pkg::ANA_RESET), "off");
		bus(1'b1, 8'h0c, 8'h0, 8'h0);
		bus(1'b1, 8'h08, 8'h0, 8'h0);
		bus(1'b1, 8'h04, 8'h02, 8'h0);
		bus(1'b1, 8'h14, 8'h01, 8'h0);
		bus(1'b1, 8'h00, 8'h80, 8'h0);
		bus(1'b1, 8'h10, 8'h90, 8'h0);
		settle(8);
		bus(1'b1, 8'h24, 8'h03, 8'h0);
		prev = 2'b10;
		for (int i = 0; i < 10; i++) begin
			seed = lfsr(seed);
			above <= seed[1:0];
			r = seed[1:0] ^ 2'b10;
			f = {~r[1] & prev[1], r[0] & ~prev[0]};
			prev = r;
			settle(8);
			check(32'(res), 32'(r), "result");
			check(32'(pin), 32'(r), "pin");
			bus(1'b0, 8'h20, 8'h0, 8'(r));
			bus(1'b0, 8'h00, 8'h0, {1'b1, r[0], 6'h0});
			bus(1'b0, 8'h24, 8'h0, 8'(f));
			bus(1'b1, 8'h24, 8'h03, 8'h0);
		end
		bus(1'b1, 8'h00, 8'h00, 8'h0);
		settle(8);
		bus(1'b1, 8'h24, 8'h03, 8'h0);
		bus(1'b1, 8'h00, 8'h10, 8'h0);
		settle(8);
		check(32'(flag), 32'h1, "flag");
		bus(1'b1, 8'h00, 8'h81, 8'h0);
		tclk <= 1'b1;
		above <= 2'b00;
		repeat (8) @(posedge clk_i);
		tclk <= 1'b0;
		repeat (8) @(posedge clk_i);
		tclk <= 1'b1;
		above <= 2'b01;
		settle(8);
		check(32'({res[0], pin[0]}), 32'h2, "held");
		@(posedge clk_i);
		tclk <= 1'b0;
		settle(8);
		check(32'({gate[0], pin[0]}), 32'h3, "synced");
		wrap_up();
	end
endmodule
`default_nettype wire
